// *** design/sees_pkg.sv ***
// Package: opcodes, status layout and timing constants for the serial EEPROM slave
package sees_pkg;
    // ------------------------------------------------------------------
    // Opcodes (low nibble patterns, bit 3 don't care or address bit)
    // ------------------------------------------------------------------
    localparam logic [3:0] OP_HI_NIBBLE          = 4'h0;
    localparam logic [2:0] OP_SET_WRITE_ENABLE   = 3'h6;
    localparam logic [2:0] OP_CLEAR_WRITE_ENABLE = 3'h4;
    localparam logic [2:0] OP_READ_STATUS        = 3'h5;
    localparam logic [2:0] OP_WRITE_STATUS       = 3'h1;
    localparam logic [2:0] OP_READ_ARRAY         = 3'h3;
    localparam logic [2:0] OP_WRITE_ARRAY        = 3'h2;
    localparam int         OP_ADDR_BIT           = 3;
    // ------------------------------------------------------------------
    // Status register layout
    // ------------------------------------------------------------------
    localparam int         ST_READY_BUSY_BIT     = 0;
    localparam int         ST_WEL_BIT            = 1;
    localparam int         ST_BP_LO_BIT          = 2;
    localparam int         ST_BP_HI_BIT          = 3;
    localparam logic [3:0] ST_MIRROR_BUSY        = 4'hF;
    localparam logic [3:0] ST_MIRROR_IDLE        = 4'h0;
    localparam logic [1:0] BP_RESET              = 2'h0;
    localparam logic [1:0] BP_NONE               = 2'h0;
    localparam logic [1:0] BP_QUARTER            = 2'h1;
    localparam logic [1:0] BP_HALF               = 2'h2;
    localparam logic [1:0] BP_ALL                = 2'h3;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int         CORE_CLK_HZ           = 20000000;
    localparam int         WRITE_CYCLE_MS        = 5;
    localparam int         WRITE_CYCLE_CYCLES    = (CORE_CLK_HZ / 1000) * WRITE_CYCLE_MS;
    // ------------------------------------------------------------------
    // Link engine states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        SEES_OPCODE  = 5'b00001,
        SEES_ADDRESS = 5'b00010,
        SEES_DATA_IN = 5'b00100,
        SEES_SHIFT   = 5'b01000,
        SEES_IGNORE  = 5'b10000
    } sees_link_type;
endpackage

// *** design/sees_sync2.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sees_sync2 (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Level
    input  wire logic d_i,
    output var  logic q_o
);
    logic meta;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule
`default_nettype wire

// *** design/sees_slave.sv ***
// Serial EEPROM slave: link engine on the serial clock, status and write timer on core clock
// Notes on behaviour
// - Modes 0 and 3: sample input on rising edge, drive output on falling edge.
// - Deselected: serial input ignored, serial output high impedance.
// - Input shifted most significant bit first, from first rising edge after select.
// - Read output most significant bit first, from first falling edge after opcode; only read status drives it here, read array never enables the output.
// - Eight-bit opcode register; first byte after select falls is the opcode.
// - Unknown opcode: ignore input, output off until next select fall.
// - Suspend never pauses a running internal write cycle.
// - Suspend entered while selected, in clock low phase; held while both asserted.
// - Suspend left when released during clock low phase, else next low phase.
// - Suspended: output off, input and clock ignored; write protect still acts.
// - Select released while suspended: abort operation, clear write enable latch.
// - Write protect low inhibits writes; no effect once write cycle started.
// - Decode set write enable, clear write enable and read status opcodes.
// - Decode write status, read array and write array opcodes.
// - Opcode bit 3 is the ninth address bit on the largest variant.
// - Status: bits 3:2 block protect, bit 1 write enable, bit 0 busy.
// - Status bits 7:4 read ones while writing, zeros otherwise.
// - Block protect 00 none, 01 quarter, 10 half, 11 whole array.
// - Busy reads 1 during internal operation; write enable resets to 0.
// - Read status opcode shifts out the full eight-bit status.
// - During internal write every command except read status is ignored.
`timescale 1ns/1ps
`default_nettype none
module sees_slave
    import sees_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
    // Core clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // Serial link
    input  wire logic       sclk_i,
    input  wire logic       select_n_i,
    input  wire logic       sdata_i,
    output var  logic       sdata_o,
    output var  logic       sdata_oe_o,
    input  wire logic       suspend_n_i,
    input  wire logic       write_protect_n_i,
    // Variant and array side
    input  wire logic       addr_bit8_en_i,
    output var  logic [1:0] block_protect_o,
    output var  logic       array_write_o,
    output var  logic [8:0] array_addr_o,
    output var  logic [7:0] array_wdata_o,
    output var  logic       busy_o
);
    // ------------------------------------------------------------------
    // Serial clock domain: shift engine
    // ------------------------------------------------------------------
    sees_link_type link_state;
    logic [7:0] opcode;
    logic [7:0] shreg;
    logic [2:0] bit_cnt;
    logic       suspended;
    logic       susp_low;
    logic       out_bit;
    logic       out_en;
    logic [7:0] tx_byte;
    logic [7:0] status_s;
    logic       cmd_tgl;
    logic [2:0] cmd_code;
    logic [7:0] cmd_data;
    logic [8:0] cmd_addr;
    logic       cmd_valid;
    logic [7:0] status_q;
    logic       busy;
    logic       abort_pend;
    logic [8:0] cmd_addr_q;
    logic [7:0] cmd_data_q;

    // Opcode classification, used once, when the opcode byte completes
    function automatic logic op_known(input logic [7:0] op);
        logic [2:0] lo;
        lo = op[2:0];
        op_known = (op[7:4] == OP_HI_NIBBLE) && (lo != 3'h0) && (lo != 3'h7);
    endfunction

    // Level at the end of the low phase carries through the high phase
    always_ff @(posedge sclk_i or posedge select_n_i) begin
        if (select_n_i) begin
            susp_low <= 1'b0;
        end else begin
            susp_low <= ~suspend_n_i;
        end
    end
    // Clock low: pin acts at once; both edges read the pin itself, so no race
    always_comb begin
        if (select_n_i) begin
            suspended = 1'b0;
        end else if (!sclk_i) begin
            suspended = ~suspend_n_i;
        end else begin
            suspended = susp_low;
        end
    end

    // Input shifting: clock ignored while suspended or deselected
    always_ff @(posedge sclk_i or posedge select_n_i) begin
        if (select_n_i) begin
            link_state <= SEES_OPCODE;
            shreg      <= 8'h00;
            bit_cnt    <= 3'h0;
            opcode     <= 8'h00;
            cmd_valid  <= 1'b0;
            cmd_addr   <= 9'h000;
            cmd_data   <= 8'h00;
        end else if (suspend_n_i) begin
            shreg   <= {shreg[6:0], sdata_i};
            bit_cnt <= bit_cnt + 3'h1;
            unique case (link_state)
                SEES_OPCODE: begin
                    if (bit_cnt == 3'h7) begin
                        opcode <= {shreg[6:0], sdata_i};
                        if (!op_known({shreg[6:0], sdata_i})) begin
                            link_state <= SEES_IGNORE;
                        end else if (status_s[ST_READY_BUSY_BIT] &&
                                     {shreg[1:0], sdata_i} != OP_READ_STATUS) begin
                            link_state <= SEES_IGNORE;
                        end else begin
                            unique case ({shreg[1:0], sdata_i})
                                OP_READ_STATUS: link_state <= SEES_SHIFT;
                                OP_READ_ARRAY, OP_WRITE_ARRAY: begin
                                    link_state  <= SEES_ADDRESS;
                                    cmd_addr[8] <= addr_bit8_en_i & shreg[OP_ADDR_BIT - 1];
                                end
                                OP_WRITE_STATUS: link_state <= SEES_DATA_IN;
                                default: begin
                                    link_state <= SEES_IGNORE;
                                    cmd_valid  <= 1'b1;
                                end
                            endcase
                        end
                    end
                end
                SEES_ADDRESS: begin
                    if (bit_cnt == 3'h7) begin
                        cmd_addr[7:0] <= {shreg[6:0], sdata_i};
                        link_state    <= (opcode[2:0] == OP_READ_ARRAY) ? SEES_SHIFT
                                                                         : SEES_DATA_IN;
                    end
                end
                SEES_DATA_IN: begin
                    if (bit_cnt == 3'h7) begin
                        cmd_data   <= {shreg[6:0], sdata_i};
                        cmd_valid  <= 1'b1;
                        link_state <= SEES_IGNORE;
                    end
                end
                SEES_SHIFT: begin
                end
                SEES_IGNORE: begin
                end
            endcase
        end
    end

    // Output on falling edge, first bit right after the opcode
    always_ff @(negedge sclk_i or posedge select_n_i) begin
        if (select_n_i) begin
            out_bit <= 1'b0;
            out_en  <= 1'b0;
            tx_byte <= 8'h00;
        end else if (suspend_n_i) begin
            if (link_state == SEES_SHIFT && !out_en) begin
                tx_byte <= {status_s[6:0], status_s[7]};
                out_bit <= status_s[7];
                out_en  <= (opcode[2:0] == OP_READ_STATUS);
            end else if (out_en) begin
                tx_byte <= {tx_byte[6:0], tx_byte[7]};
                out_bit <= tx_byte[7];
            end
        end
    end

    // Output driven only while selected and not suspended
    always_comb begin
        sdata_oe_o = out_en & ~select_n_i & ~suspended;
        sdata_o    = out_bit;
    end

    // Command handed over on select rise; abort when suspended then
    always_ff @(posedge select_n_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_tgl    <= 1'b0;
            cmd_code   <= 3'h0;
            abort_pend <= 1'b0;
            cmd_addr_q <= 9'h000;
            cmd_data_q <= 8'h00;
        end else begin
            cmd_tgl    <= ~cmd_tgl;
            cmd_code   <= cmd_valid ? opcode[2:0] : 3'h0;
            abort_pend <= ~suspend_n_i;
            // Link side clears on deselect, so keep a copy for the core side
            cmd_addr_q <= cmd_addr;
            cmd_data_q <= cmd_data;
        end
    end

    // Status snapshot into link domain through two stages per bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_st_sync
            sees_sync2 u_sync (
                .clk_i   (sclk_i),
                .rst_n_i (rst_n_i),
                .d_i     (status_q[gi]),
                .q_o     (status_s[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Core clock domain: status register and write timer
    // ------------------------------------------------------------------
    logic        tgl_s;
    logic        tgl_d;
    logic        wp_on_s;
    logic        sel_on_s;
    logic        write_enable_latch;
    logic [1:0]  bp;
    logic [31:0] wc_cnt;
    logic        wp_hit;

    sees_sync2 u_tgl (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(cmd_tgl), .q_o(tgl_s));
    // Synchronised as active levels, so reset leaves them idle
    sees_sync2 u_wp  (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(~write_protect_n_i),
                      .q_o(wp_on_s));
    sees_sync2 u_sel (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .d_i(~select_n_i),
                      .q_o(sel_on_s));

    // Write protect low during the frame kills the pending write
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_d  <= 1'b0;
            wp_hit <= 1'b0;
        end else begin
            tgl_d <= tgl_s;
            if (tgl_s != tgl_d) begin
                wp_hit <= 1'b0;
            end else if (sel_on_s && wp_on_s) begin
                wp_hit <= 1'b1;
            end
        end
    end

    // Command execution; timer runs on regardless of suspend
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_enable_latch            <= 1'b0;
            bp             <= BP_RESET;
            busy           <= 1'b0;
            wc_cnt         <= 32'h0000_0000;
            array_write_o  <= 1'b0;
            array_addr_o   <= 9'h000;
            array_wdata_o  <= 8'h00;
        end else begin
            array_write_o <= 1'b0;
            if (busy) begin
                if (wc_cnt == 32'h0000_0001) begin
                    busy <= 1'b0;
                    write_enable_latch  <= 1'b0;
                end
                wc_cnt <= wc_cnt - 32'h0000_0001;
            end else if (tgl_s != tgl_d) begin
                if (abort_pend) begin
                    write_enable_latch <= 1'b0;
                end else begin
                    unique case (cmd_code)
                        OP_SET_WRITE_ENABLE:   write_enable_latch <= ~wp_on_s;
                        OP_CLEAR_WRITE_ENABLE: write_enable_latch <= 1'b0;
                        OP_WRITE_STATUS, OP_WRITE_ARRAY: begin
                            if (write_enable_latch && !wp_on_s && !wp_hit) begin
                                busy   <= 1'b1;
                                wc_cnt <= WRITE_CYCLES[31:0];
                                if (cmd_code == OP_WRITE_STATUS) begin
                                    bp <= cmd_data_q[ST_BP_HI_BIT:ST_BP_LO_BIT];
                                end else begin
                                    array_write_o <= 1'b1;
                                    array_addr_o  <= cmd_addr_q;
                                    array_wdata_o <= cmd_data_q;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // Status word assembly
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_q        <= 8'h00;
            block_protect_o <= BP_RESET;
            busy_o          <= 1'b0;
        end else begin
            status_q        <= {(busy ? ST_MIRROR_BUSY : ST_MIRROR_IDLE), bp, write_enable_latch, busy};
            block_protect_o <= bp;
            busy_o          <= busy;
        end
    end
endmodule
`default_nettype wire

// *** verif/sees_slave_sva.sv ***
// Checker: port-level assertions for the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module sees_slave_sva
    import sees_pkg::*;
#(
    parameter int WRITE_CYCLES = 20
) (
    // Core side
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // Serial link
    input  wire logic       sclk_i,
    input  wire logic       select_n_i,
    input  wire logic       sdata_i,
    input  wire logic       sdata_o,
    input  wire logic       sdata_oe_o,
    input  wire logic       suspend_n_i,
    input  wire logic       write_protect_n_i,
    // Array side
    input  wire logic       addr_bit8_en_i,
    input  wire logic [1:0] block_protect_o,
    input  wire logic       array_write_o,
    input  wire logic [8:0] array_addr_o,
    input  wire logic [7:0] array_wdata_o,
    input  wire logic       busy_o
);
    logic       link_rst;
    logic       read_status_cmd_op;
    logic [4:0] bit_cnt;
    logic [7:0] op_q;
    int         busy_cnt;
    // ------------------------------------------------------------------
    // Helpers: held edges are not counted, as the device ignores them
    // ------------------------------------------------------------------
    assign link_rst = select_n_i | ~rst_n_i;
    assign read_status_cmd_op  = (op_q[7:4] == OP_HI_NIBBLE) && (op_q[2:0] == OP_READ_STATUS);
    always_ff @(posedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt <= 5'h00;
        end else if (suspend_n_i && bit_cnt != 5'h1F) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end
    always_ff @(posedge sclk_i or posedge link_rst) begin
        if (link_rst) begin
            op_q <= 8'h00;
        end else if (suspend_n_i && bit_cnt < 5'h08) begin
            op_q <= {op_q[6:0], sdata_i};
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_o ? busy_cnt + 1 : 0;
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    deselect_hiz_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        select_n_i |-> !sdata_oe_o) else $error("output driven while deselected");
    held_hiz_a: assert property (@(posedge sclk_i) disable iff (link_rst)
        !suspend_n_i && !$past(suspend_n_i) |-> !sdata_oe_o) else $error("driven while held");
    early_drive_a: assert property (@(posedge sclk_i) disable iff (link_rst)
        sdata_oe_o |-> bit_cnt >= 5'h08) else $error("output before opcode done");
    read_status_cmd_drive_a: assert property (@(posedge sclk_i) disable iff (link_rst)
        bit_cnt == 5'h08 && read_status_cmd_op && suspend_n_i |-> sdata_oe_o) else $error("no status");
    bp_order_a: assert property (@(posedge sclk_i) disable iff (link_rst)
        bit_cnt == 5'h0C && read_status_cmd_op && suspend_n_i && !busy_o |-> sdata_o == block_protect_o[1]
        ##1 sdata_o == block_protect_o[0]) else $error("protect bits out of place");
    invalid_quiet_a: assert property (@(posedge sclk_i) disable iff (link_rst)
        bit_cnt >= 5'h08 && op_q[7:4] != OP_HI_NIBBLE |-> !sdata_oe_o) else $error("bad op");
    write_busy_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        array_write_o |-> ##[0:4] busy_o) else $error("write commit without busy");
    write_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        array_write_o |=> !array_write_o) else $error("write commit longer than a cycle");
    busy_span_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(busy_o) |-> busy_cnt >= WRITE_CYCLES) else $error("write cycle cut short");
endmodule
`default_nettype wire

// *** verif/sees_master.sv ***
// Serial master model: frames in mode 0 or 3, samples device output
`timescale 1ns/1ps
`default_nettype none
module sees_master (
    // Link pins
    output var  logic sclk_o,
    output var  logic select_n_o,
    output var  logic sdata_o,
    output var  logic suspend_n_o,
    input  wire logic sdata_i,
    input  wire logic sdata_oe_i
);
    initial begin
        sclk_o = 1'b0;
        select_n_o = 1'b1;
        sdata_o = 1'b0;
        suspend_n_o = 1'b1;
    end
    // Hold before bit h; abort deselects while still held
    task automatic frame(input bit c, input logic [23:0] d, input int n, input int h,
                         input bit ab, output logic [7:0] rd, output bit oe, output bit oeh);
        rd = 8'h00;
        oe = 1'b0;
        oeh = 1'b0;
        sclk_o = c; // Same idle level before and after
        #7.5 select_n_o = 1'b0; // Master opens every frame
        #7.5;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b0;
            if (i == h) begin
                #1 suspend_n_o = 1'b0; // Clear of the falling edge, inside the low phase
                repeat (3) begin
                    sdata_o = ~sdata_o;
                    #7.5 sclk_o = 1'b1;
                    #1 oeh |= sdata_oe_i; // Settled high-phase level
                    #6.5 sclk_o = 1'b0;
                end
                if (ab) break;
                #7.5 suspend_n_o = 1'b1;
            end
            sdata_o = d[n-1-i]; // Most significant bit first
            #7.5 sclk_o = 1'b1; // Sample on rising edge
            rd = {rd[6:0], sdata_i};
            oe |= sdata_oe_i;
            #7.5;
        end
        sclk_o = c;
        #7.5 select_n_o = 1'b1;
        sdata_o = ~sdata_o; // Released line: no stale value
        #7.5 suspend_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Testbench: serial EEPROM slave against the master model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module testbench;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       wp_n = 1'b1;
    logic       a8_en = 1'b0;
    logic       sclk, select_n, mosi, miso, miso_oe, suspend_n, awr, busy;
    logic [1:0] bp;
    logic [8:0] aaddr, wr_addr;
    logic [7:0] adata, wr_data, st;
    int         error_cnt = 0;
    int         checks_done = 0;
    int         wr_cnt = 0;
    int         n0;
    bit         oe, oeh;
    always #25 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        if (awr === 1'b1) begin
            wr_cnt++;
            wr_addr = aaddr;
            wr_data = adata;
        end
    end
    sees_slave #(.WRITE_CYCLES(40)) dut (.core_clk_i(core_clk), .rst_n_i(rst_n),
        .sclk_i(sclk), .select_n_i(select_n), .sdata_i(mosi), .sdata_o(miso),
        .sdata_oe_o(miso_oe), .suspend_n_i(suspend_n), .write_protect_n_i(wp_n),
        .addr_bit8_en_i(a8_en), .block_protect_o(bp), .array_write_o(awr),
        .array_addr_o(aaddr), .array_wdata_o(adata), .busy_o(busy));
    sees_master m (.sclk_o(sclk), .select_n_o(select_n), .sdata_o(mosi),
        .suspend_n_o(suspend_n), .sdata_i(miso), .sdata_oe_i(miso_oe));
    // Commands act at select rise, so leave room before the next frame
    task automatic xf(input bit c, input logic [23:0] d, input int n, input int h = 99,
                      input bit ab = 1'b0);
        m.frame(c, d, n, h, ab, st, oe, oeh);
        repeat (6) @(negedge core_clk);
    endtask
    task automatic read_status_cmd(input bit c, input int h = 99);
        xf(c, 24'h00_0500, 16, h);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge core_clk);
        `CHK("busy", 1'b0, busy)
        repeat (4) @(negedge core_clk);
    endtask
    task automatic t_wel;
        logic [7:0] ops [4] = '{8'h06, 8'h0C, 8'h0E, 8'h04};
        `CHK("bp_rst", 2'h0, bp)
        read_status_cmd(1'b1);
        `CHK("st_rst", 8'h00, st)
        for (int i = 0; i < 4; i++) begin
            xf(i[0], {16'h0000, ops[i]}, 8);
            read_status_cmd(i[0]);
            `CHK("wel", {6'h00, ~i[0], 1'b0}, st)
        end
        @(negedge core_clk) wp_n = 1'b0;
        xf(1'b0, 24'h00_0006, 8);
        read_status_cmd(1'b0);
        `CHK("wel_wp", 8'h00, st)
        @(negedge core_clk) wp_n = 1'b1;
    endtask
    task automatic t_bp;
        for (int b = 3; b >= 0; b--) begin
            xf(1'b0, 24'h00_0006, 8);
            xf(1'b1, {8'h01, 4'h0, b[1:0], 2'h0}, 16);
            read_status_cmd(1'b0);
            `CHK("mirror", 4'hF, st[7:4])
            `CHK("busy_bit", 1'b1, st[0])
            xf(1'b0, 24'h00_0006, 8);
            wait_idle();
            read_status_cmd(1'b1);
            `CHK("st_bp", {4'h0, b[1:0], 2'h0}, st)
            `CHK("bp_o", b[1:0], bp)
        end
    endtask
    task automatic t_write;
        for (int k = 0; k < 4; k++) begin
            @(negedge core_clk) a8_en = k[0];
            xf(1'b0, 24'h00_0006, 8);
            @(negedge core_clk) wp_n = ~k[1];
            n0 = wr_cnt;
            xf(k[0], 24'h0A_345A, 24);
            wait_idle();
            `CHK("wr_cnt", n0 + !k[1], wr_cnt)
            if (!k[1]) begin
                `CHK("wr_addr", {k[0], 8'h34}, wr_addr)
                `CHK("wr_data", 8'h5A, wr_data)
            end
        end
        @(negedge core_clk) wp_n = 1'b1;
    endtask
    task automatic t_misc;
        xf(1'b0, 24'h00_0004, 8);
        xf(1'b0, 24'h00_8505, 16);
        `CHK("oe_bad", 1'b0, oe)
        xf(1'b0, 24'h00_0006, 8);
        n0 = wr_cnt;
        fork
            xf(1'b0, 24'h02_1122, 24);
            begin
                repeat (3) @(negedge core_clk);
                wp_n = 1'b0;
                repeat (2) @(negedge core_clk);
                wp_n = 1'b1;
            end
        join
        wait_idle();
        `CHK("wp_pulse", n0, wr_cnt)
        read_status_cmd(1'b0, 11);
        `CHK("oe_held", 1'b0, oeh)
        `CHK("st_held", 8'h02, st)
        xf(1'b1, 24'h00_0006, 8, 4, 1'b1);
        read_status_cmd(1'b0);
        `CHK("st_abort", 8'h00, st)
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_wel();
        t_bp();
        t_write();
        t_misc();
        give_verdict();
    end
    // Whole run needs well under 60 us
    initial begin
        #200_000;
        error_cnt++;
        give_verdict();
    end
endmodule
bind sees_slave sees_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .select_n_i(select_n_i),
    .sdata_i(sdata_i), .sdata_o(sdata_o), .sdata_oe_o(sdata_oe_o), .suspend_n_i(suspend_n_i),
    .write_protect_n_i(write_protect_n_i), .addr_bit8_en_i(addr_bit8_en_i),
    .block_protect_o(block_protect_o), .array_write_o(array_write_o),
    .array_addr_o(array_addr_o), .array_wdata_o(array_wdata_o), .busy_o(busy_o));
`default_nettype wire
